/* hw/icr_handler.sv */
// Purpose: Two-level interrupt handler for a small 8-bit core.
// Assumes: Core pulses ack when it starts the long call to the offered
//          vector, and pulses return_from_irq_insn when a return-from-interrupt completes.
// Notes:   Register reads answer one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module icr_handler
    import icr_pkg::*;
(
    // Clock and reset.
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    // Register port.
    input  wire icr_bus_type        bus_in,
    output var  logic [7:0]         rdata_reg,
    // Peripheral event pulses, one per source index.
    input  wire logic [NUM_SRC-1:0] periph_evt,
    // External interrupt pins, active low.
    input  wire logic               ext_irq_in_0_n,
    input  wire logic               ext_irq_in_1_n,
    // Core side.
    input  wire icr_core_type       core_in,
    output var  icr_call_type       call_reg
);
    // Peripheral events only drive the sources that have no own set path.
    localparam logic [NUM_SRC-1:0] HW_MASK = 22'h30fffa;

    logic [7:0]         irq_enable_reg;
    logic [7:0]         ext_enable_reg_1;
    logic [7:0]         extended_irq_enable_reg_2;
    logic [7:0]         prio_reg;
    logic [7:0]         ext_prio_reg_1;
    logic [7:0]         ext_prio_reg_2;
    logic               ext0_type_select;
    logic               ext1_type_select;
    logic [NUM_SRC-1:0] pend_reg;
    logic [NUM_SRC-1:0] pend_next;
    logic [1:0]         sync1_reg;
    logic [1:0]         sync2_reg;
    logic [1:0]         sync3_reg;
    logic [1:0]         ext_fall;
    logic               isr_hi_reg;
    logic               isr_lo_reg;
    logic [IDX_W-1:0]   sel_reg;
    logic               global_irq_enable;
    logic [NUM_SRC-1:0] en_vec;
    logic [NUM_SRC-1:0] hi_vec;
    logic [NUM_SRC-1:0] elig;
    logic [NUM_SRC-1:0] sw_we;
    logic [NUM_SRC-1:0] sw_wv;
    logic [NUM_SRC-1:0] auto_clr;
    logic               pick_any;
    logic               pick_hi;
    logic [IDX_W-1:0]   pick_idx;
    logic [7:0]         rd_mux;

    assign global_irq_enable = irq_enable_reg[GLOBAL_EN_BIT];
    assign en_vec = {extended_irq_enable_reg_2, ext_enable_reg_1, irq_enable_reg[5:0]};
    assign hi_vec = {ext_prio_reg_2, ext_prio_reg_1, prio_reg[5:0]};

    // Enable and priority registers.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_enable_reg            <= RST_BYTE;
            ext_enable_reg_1          <= RST_BYTE;
            extended_irq_enable_reg_2 <= RST_BYTE;
            prio_reg                  <= RST_BYTE;
            ext_prio_reg_1            <= RST_BYTE;
            ext_prio_reg_2            <= RST_BYTE;
            ext0_type_select          <= 1'b0;
            ext1_type_select          <= 1'b0;
        end else if (bus_in.wr) begin
            unique case (bus_in.addr)
                ADDR_IRQ_EN:   irq_enable_reg <= {bus_in.wdata[7], 1'b0, bus_in.wdata[5:0]};
                ADDR_EN_X1:    ext_enable_reg_1 <= bus_in.wdata;
                ADDR_EN_X2:    extended_irq_enable_reg_2 <= bus_in.wdata;
                ADDR_PRIO:     prio_reg <= {2'b00, bus_in.wdata[5:0]};
                ADDR_PRIO_X1:  ext_prio_reg_1 <= bus_in.wdata;
                ADDR_PRIO_X2:  ext_prio_reg_2 <= bus_in.wdata;
                ADDR_TMR_CTRL: begin
                    ext0_type_select <= bus_in.wdata[EXT0_TYPE_BIT];
                    ext1_type_select <= bus_in.wdata[EXT1_TYPE_BIT];
                end
                default: ;
            endcase
        end
    end

    // Pins pass two flops; the third stage only serves the edge detector.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg <= 2'b11;
            sync2_reg <= 2'b11;
            sync3_reg <= 2'b11;
        end else begin
            sync1_reg <= {ext_irq_in_1_n, ext_irq_in_0_n};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign ext_fall = sync3_reg & ~sync2_reg;

    // Software write decode onto per-source write enable and value.
    always_comb begin
        sw_we = '0;
        sw_wv = '0;
        if (bus_in.wr) begin
            unique case (bus_in.addr)
                ADDR_PEND0: begin
                    sw_we[7:0] = 8'hff;
                    sw_wv[7:0] = bus_in.wdata;
                end
                ADDR_PEND1: begin
                    sw_we[15:8] = 8'hff;
                    sw_wv[15:8] = bus_in.wdata;
                end
                ADDR_PEND2: begin
                    sw_we[21:16] = 6'h3f;
                    sw_wv[21:16] = bus_in.wdata[5:0];
                end
                ADDR_TMR_CTRL: begin
                    sw_we[SRC_EXT0] = 1'b1;
                    sw_wv[SRC_EXT0] = bus_in.wdata[EXT0_FLAG_BIT];
                    sw_we[SRC_EXT1] = 1'b1;
                    sw_wv[SRC_EXT1] = bus_in.wdata[EXT1_FLAG_BIT];
                end
                ADDR_SOFT_IRQ: begin
                    sw_we[SRC_SOFT0 +: NUM_SOFT] = 4'hf;
                    sw_wv[SRC_SOFT0 +: NUM_SOFT] = bus_in.wdata[SOFT_LSB +: NUM_SOFT];
                end
                default: ;
            endcase
        end
    end

    // Only edge-mode external flags clear on vectoring; level-mode ones follow the pin, the rest wait for software.
    always_comb begin
        auto_clr = '0;
        if (core_in.ack) begin
            auto_clr[SRC_EXT0] = ext0_type_select && (sel_reg == IDX_W'(SRC_EXT0));
            auto_clr[SRC_EXT1] = ext1_type_select && (sel_reg == IDX_W'(SRC_EXT1));
        end
    end

    // Per-source pending flag; a set in the same cycle as a clear wins.
    generate
        for (genvar i = 0; i < NUM_SRC; i++) begin : g_pend
            logic hw_set;
            if (i == SRC_EXT0) begin : g_e0
                assign hw_set = ext_fall[0];
                always_comb begin
                    if (!ext0_type_select) begin
                        pend_next[i] = ~sync2_reg[0];
                    end else if (hw_set || (sw_we[i] && sw_wv[i])) begin
                        pend_next[i] = 1'b1;
                    end else if (auto_clr[i] || sw_we[i]) begin
                        pend_next[i] = 1'b0;
                    end else begin
                        pend_next[i] = pend_reg[i];
                    end
                end
            end else if (i == SRC_EXT1) begin : g_e1
                assign hw_set = ext_fall[1];
                always_comb begin
                    if (!ext1_type_select) begin
                        pend_next[i] = ~sync2_reg[1];
                    end else if (hw_set || (sw_we[i] && sw_wv[i])) begin
                        pend_next[i] = 1'b1;
                    end else if (auto_clr[i] || sw_we[i]) begin
                        pend_next[i] = 1'b0;
                    end else begin
                        pend_next[i] = pend_reg[i];
                    end
                end
            end else begin : g_gen
                assign hw_set = periph_evt[i] & HW_MASK[i];
                always_comb begin
                    if (hw_set || (sw_we[i] && sw_wv[i])) begin
                        pend_next[i] = 1'b1;
                    end else if (sw_we[i]) begin
                        pend_next[i] = 1'b0;
                    end else begin
                        pend_next[i] = pend_reg[i];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pend_reg <= RST_PEND;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // A source can ask only while enabled, globally enabled, and above the running level.
    always_comb begin
        for (int k = 0; k < NUM_SRC; k++) begin
            elig[k] = pend_reg[k] && en_vec[k] && global_irq_enable
                      && !isr_hi_reg && (!isr_lo_reg || hi_vec[k]);
        end
    end

    // Highest level first, then lowest index.
    always_comb begin
        pick_any = 1'b0;
        pick_hi  = 1'b0;
        pick_idx = '0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (elig[k] && !hi_vec[k] && !pick_hi) begin
                pick_any = 1'b1;
                pick_idx = IDX_W'(k);
            end
        end
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (elig[k] && hi_vec[k]) begin
                pick_any = 1'b1;
                pick_hi  = 1'b1;
                pick_idx = IDX_W'(k);
            end
        end
    end

    // Decoded every cycle; the ack cycle is masked so a taken request is not offered twice.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            call_reg <= '0;
            sel_reg  <= '0;
        end else begin
            call_reg.req    <= pick_any && !core_in.ack;
            call_reg.high   <= pick_hi;
            call_reg.vector <= VEC_BASE + 16'(pick_idx) * VEC_STEP;
            sel_reg         <= pick_idx;
        end
    end

    // In-service levels; a return ends the highest level in service.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            isr_hi_reg <= 1'b0;
            isr_lo_reg <= 1'b0;
        end else if (core_in.ack && call_reg.req) begin
            if (call_reg.high) begin
                isr_hi_reg <= 1'b1;
            end else begin
                isr_lo_reg <= 1'b1;
            end
        end else if (core_in.return_from_irq_insn) begin
            if (isr_hi_reg) begin
                isr_hi_reg <= 1'b0;
            end else begin
                isr_lo_reg <= 1'b0;
            end
        end
    end

    // Read path.
    always_comb begin
        unique case (bus_in.addr)
            ADDR_IRQ_EN:   rd_mux = irq_enable_reg;
            ADDR_EN_X1:    rd_mux = ext_enable_reg_1;
            ADDR_EN_X2:    rd_mux = extended_irq_enable_reg_2;
            ADDR_PRIO:     rd_mux = prio_reg;
            ADDR_PRIO_X1:  rd_mux = ext_prio_reg_1;
            ADDR_PRIO_X2:  rd_mux = ext_prio_reg_2;
            ADDR_TMR_CTRL: rd_mux = {4'h0, pend_reg[SRC_EXT1], ext1_type_select,
                                     pend_reg[SRC_EXT0], ext0_type_select};
            ADDR_SOFT_IRQ: rd_mux = {pend_reg[SRC_SOFT0 +: NUM_SOFT], 4'h0};
            ADDR_PEND0:    rd_mux = pend_reg[7:0];
            ADDR_PEND1:    rd_mux = pend_reg[15:8];
            ADDR_PEND2:    rd_mux = {2'b00, pend_reg[21:16]};
            ADDR_ISR:      rd_mux = {6'h00, isr_hi_reg, isr_lo_reg};
            default:       rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= RST_BYTE;
        end else if (bus_in.rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= RST_BYTE;
        end
    end

    // Checks.
    AST_GLOBAL_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !global_irq_enable |=> !call_reg.req) else $error("request while globally disabled");

    AST_MASKED: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ((pend_reg & en_vec) == '0) |=> !call_reg.req) else $error("request from disabled source");

    AST_RAISE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (|elig && !core_in.ack) |=> call_reg.req) else $error("eligible source not requested");

    AST_HW_SET: assert property (@(posedge clk_sys) disable iff (sys_rst)
        |(periph_evt & HW_MASK) |=> ((($past(periph_evt) & HW_MASK) & ~pend_reg) == '0))
        else $error("peripheral event lost");

    AST_SOFT_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (pend_reg[SRC_SOFT0] && !(bus_in.wr && (bus_in.addr == ADDR_SOFT_IRQ || bus_in.addr == ADDR_PEND2)))
        |=> pend_reg[SRC_SOFT0]) else $error("software flag cleared by hardware");

    AST_LEVEL: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !ext0_type_select |=> pend_reg[SRC_EXT0] == !$past(sync2_reg[0]))
        else $error("level flag does not follow pin");

    AST_EDGE_CLR: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (auto_clr[SRC_EXT0] && !ext_fall[0] && !bus_in.wr) |=> !pend_reg[SRC_EXT0])
        else $error("edge flag not cleared on vectoring");

    AST_NO_PREEMPT_HI: assert property (@(posedge clk_sys) disable iff (sys_rst)
        isr_hi_reg |-> !call_reg.req ##1 !call_reg.req) else $error("high routine preempted");

    AST_SW_SET: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (bus_in.wr && bus_in.addr == ADDR_PEND1 && bus_in.wdata[0]) |=> pend_reg[8])
        else $error("software set not taken");

    AST_HI_FIRST: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (|(elig & hi_vec) && !core_in.ack) |=> call_reg.high) else $error("low chosen over high");
endmodule : icr_handler
`default_nettype wire

/* hw/icr_pkg.sv */
// Purpose: Shared constants and carrier types of the interrupt handler.
// Assumes: Byte-wide register port; 22 sources numbered in fixed priority order.
// Notes:   Source index n vectors to VEC_BASE + n * VEC_STEP.
package icr_pkg;
    localparam int         NUM_SRC       = 22;
    localparam int         IDX_W         = 5;
    // Source positions in the fixed priority order.
    localparam int         SRC_EXT0      = 0;
    localparam int         SRC_EXT1      = 2;
    localparam int         SRC_SOFT0     = 16;
    localparam int         NUM_SOFT      = 4;
    // Register offsets.
    localparam logic [7:0] ADDR_TMR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'ha8;
    localparam logic [7:0] ADDR_SOFT_IRQ = 8'had;
    localparam logic [7:0] ADDR_PRIO     = 8'hb8;
    localparam logic [7:0] ADDR_EN_X1    = 8'he6;
    localparam logic [7:0] ADDR_EN_X2    = 8'he7;
    localparam logic [7:0] ADDR_PRIO_X1  = 8'hf6;
    localparam logic [7:0] ADDR_PRIO_X2  = 8'hf7;
    localparam logic [7:0] ADDR_PEND0    = 8'h40;
    localparam logic [7:0] ADDR_PEND1    = 8'h41;
    localparam logic [7:0] ADDR_PEND2    = 8'h42;
    localparam logic [7:0] ADDR_ISR      = 8'h43;
    // Field positions.
    localparam int         GLOBAL_EN_BIT = 7;
    localparam int         EXT0_TYPE_BIT = 0;
    localparam int         EXT0_FLAG_BIT = 1;
    localparam int         EXT1_TYPE_BIT = 2;
    localparam int         EXT1_FLAG_BIT = 3;
    localparam int         SOFT_LSB      = 4;
    // Reset values.
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [21:0] RST_PEND     = 22'h000000;
    // Vector layout.
    localparam logic [15:0] VEC_BASE     = 16'h0003;
    localparam logic [15:0] VEC_STEP     = 16'h0008;
    // Timing: one cycle to detect, four for the long call done by the core.
    localparam int         DETECT_CYCLES = 1;
    localparam int         CALL_CYCLES   = 4;
    localparam int         MIN_RESPONSE  = DETECT_CYCLES + CALL_CYCLES;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } icr_bus_type;

    typedef struct packed {
        logic        req;
        logic        high;
        logic [15:0] vector;
    } icr_call_type;

    typedef struct packed {
        logic ack;
        logic return_from_irq_insn;
    } icr_core_type;
endpackage : icr_pkg

/* tb/icr_core_model.sv */
// Purpose: Behavioural core that takes vectored calls from the handler.
// Assumes: Acks only while a request stands; ack_dly sets how slow it is.
// Notes:   ret_go from the bench becomes a one-cycle return pulse.
`timescale 1ns/100ps
`default_nettype none
module icr_core_model
    import icr_pkg::*;
(
    // Clock and reset.
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // Handler side.
    input  wire icr_call_type call_in,
    output var  icr_core_type core_out,
    // Bench control.
    input  wire logic [3:0]   ack_dly,
    input  wire logic         ret_go
);
    logic [3:0] wait_reg;

    // Acking a dropped request would start a call to a stale vector, so the
    // wait restarts whenever the request goes away.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wait_reg <= 4'h0;
            core_out <= '0;
        end else begin
            core_out.return_from_irq_insn <= ret_go;
            core_out.ack  <= 1'b0;
            wait_reg      <= 4'h0;
            if (call_in.req && !core_out.ack) begin
                if (wait_reg >= ack_dly)
                    core_out.ack <= 1'b1;
                else
                    wait_reg <= wait_reg + 4'h1;
            end
        end
    end
endmodule : icr_core_model
`default_nettype wire

/* tb/icr_handler_tb.sv */
// Purpose: Self-checking bench for the interrupt handler.
// Assumes: Core model acks offered calls; bench drives bus, events and pins.
// Notes:   Every scenario task drives the block and judges the answers.
`timescale 1ns/100ps
`default_nettype none
module icr_handler_tb
    import icr_pkg::*;
;
    logic               clk_sys;
    logic               sys_rst;
    icr_bus_type        bus;
    logic [7:0]         rdata;
    logic [NUM_SRC-1:0] evt;
    logic               p0n;
    logic               p1n;
    icr_call_type       call;
    icr_core_type       core;
    logic [3:0]         dly;
    logic               ret_go;
    int                 mismatches = 0;
    int                 n_tests    = 0;
    int                 cyc        = 0;

    icr_handler dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_in(bus), .rdata_reg(rdata),
        .periph_evt(evt), .ext_irq_in_0_n(p0n), .ext_irq_in_1_n(p1n), .core_in(core), .call_reg(call));
    icr_core_model core_m (.clk_sys(clk_sys), .sys_rst(sys_rst), .call_in(call), .core_out(core),
        .ack_dly(dly), .ret_go(ret_go));

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 chk(what, rdata, exp);
    endtask : rd

    // Waits a bounded time for the core to start a call, then judges the offer.
    task automatic take(input int idx, input logic hi, input string what);
        repeat (40) begin
            @(posedge clk_sys);
            #1;
            if (core.ack === 1'b1) break;
        end
        chk(what, core.ack, 16'h0001);
        chk(what, call.vector, VEC_BASE + VEC_STEP * 16'(idx));
        chk(what, call.high, hi);
    endtask : take

    task automatic quiet(input int n, input string what);
        logic s;
        s = 1'b0;
        repeat (n) begin
            @(posedge clk_sys);
            #1 s = s | call.req;
        end
        chk(what, s, 16'h0000);
    endtask : quiet

    task automatic ret_irq();
        @(posedge clk_sys);
        ret_go <= 1'b1;
        @(posedge clk_sys);
        ret_go <= 1'b0;
    endtask : ret_irq

    task automatic t_regs();
        logic [7:0] a [12] = '{ADDR_IRQ_EN, ADDR_PRIO, ADDR_TMR_CTRL, ADDR_SOFT_IRQ, ADDR_EN_X1, ADDR_EN_X2,
                               ADDR_PRIO_X1, ADDR_PRIO_X2, ADDR_PEND0, ADDR_PEND1, ADDR_PEND2, ADDR_ISR};
        logic [7:0] w [8] = '{8'h7f, 8'hff, 8'hf5, 8'hff, 8'ha5, 8'h5a, 8'h3c, 8'hc3};
        logic [7:0] e [8] = '{8'h3f, 8'h3f, 8'h05, 8'hf0, 8'ha5, 8'h5a, 8'h3c, 8'hc3};
        for (int i = 0; i < 12; i++) rd(a[i], 8'h00, "reset value");
        for (int i = 0; i < 8; i++) wr(a[i], w[i]);
        for (int i = 0; i < 8; i++) rd(a[i], e[i], "readback");
        rd(ADDR_PEND2, 8'h0f, "soft flags in pending map");
        rd(8'h50, 8'h00, "unmapped");
        for (int i = 0; i < 8; i++) wr(a[i], 8'h00);
        $display("test regs done");
    endtask : t_regs

    task automatic t_gate();
        @(posedge clk_sys);
        evt <= 22'h000040;
        @(posedge clk_sys);
        evt <= '0;
        quiet(6, "disabled source");
        rd(ADDR_PEND0, 8'h40, "flag while disabled");
        wr(ADDR_EN_X1, 8'h01);
        quiet(6, "global off");
        wr(ADDR_IRQ_EN, 8'h80);
        take(6, 1'b0, "peripheral call");
        rd(ADDR_ISR, 8'h01, "low in service");
        ret_irq();
        take(6, 1'b0, "flag left set");
        wr(ADDR_PEND0, 8'h00);
        ret_irq();
        quiet(8, "flag cleared by software");
        rd(ADDR_ISR, 8'h00, "service ended");
        $display("test gate done");
    endtask : t_gate

    task automatic t_timing();
        dly <= 4'h8;
        wr(ADDR_EN_X1, 8'h02);
        @(posedge clk_sys);
        evt <= 22'h000040;
        @(posedge clk_sys);
        evt <= '0;
        quiet(4, "other source disabled");
        @(posedge clk_sys);
        evt <= 22'h000080;
        @(posedge clk_sys);
        evt <= '0;
        #1 chk("request before detect", call.req, 16'h0000);
        @(posedge clk_sys);
        #1 chk("request after detect", call.req, 16'h0001);
        take(7, 1'b0, "slow core call");
        wr(ADDR_PEND0, 8'h00);
        ret_irq();
        dly <= 4'h0;
        $display("test timing done");
    endtask : t_timing

    task automatic t_soft();
        for (int k = 0; k < NUM_SOFT; k++) begin
            wr(ADDR_EN_X2, 8'h04 << k);
            wr(ADDR_SOFT_IRQ, 8'h10 << k);
            take(SRC_SOFT0 + k, 1'b0, "soft call");
            rd(ADDR_SOFT_IRQ, 8'h10 << k, "soft flag kept");
            wr(ADDR_SOFT_IRQ, 8'h00);
            ret_irq();
        end
        quiet(4, "soft flags cleared");
        $display("test soft done");
    endtask : t_soft

    task automatic t_prio();
        wr(ADDR_IRQ_EN, 8'h00);
        wr(ADDR_EN_X1, 8'h03);
        wr(ADDR_EN_X2, 8'h80);
        wr(ADDR_PRIO_X2, 8'h80);
        wr(ADDR_PEND0, 8'hc0);
        wr(ADDR_PEND2, 8'h20);
        wr(ADDR_IRQ_EN, 8'h80);
        take(21, 1'b1, "high level first");
        quiet(6, "high not preempted");
        wr(ADDR_PEND2, 8'h00);
        ret_irq();
        take(6, 1'b0, "fixed order");
        wr(ADDR_PEND2, 8'h20);
        take(21, 1'b1, "preempt low");
        rd(ADDR_ISR, 8'h03, "both levels in service");
        wr(ADDR_PEND2, 8'h00);
        wr(ADDR_PEND0, 8'h80);
        ret_irq();
        quiet(4, "same level waits");
        ret_irq();
        take(7, 1'b0, "next in order");
        wr(ADDR_PEND0, 8'h00);
        ret_irq();
        rd(ADDR_ISR, 8'h00, "all services ended");
        $display("test prio done");
    endtask : t_prio

    task automatic t_ext();
        wr(ADDR_IRQ_EN, 8'h81);
        @(posedge clk_sys);
        p0n <= 1'b0;
        take(SRC_EXT0, 1'b0, "level call");
        rd(ADDR_TMR_CTRL, 8'h02, "level flag follows pin");
        @(posedge clk_sys);
        p0n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(ADDR_TMR_CTRL, 8'h00, "level flag released");
        ret_irq();
        quiet(6, "level released in time");
        wr(ADDR_IRQ_EN, 8'h80);
        wr(ADDR_TMR_CTRL, 8'h04);
        @(posedge clk_sys);
        p1n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        p1n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(ADDR_TMR_CTRL, 8'h0c, "edge latched");
        wr(ADDR_IRQ_EN, 8'h84);
        take(SRC_EXT1, 1'b0, "edge call");
        rd(ADDR_TMR_CTRL, 8'h04, "edge flag auto clear");
        ret_irq();
        quiet(4, "edge served once");
        // Input 0 in edge mode, so its own auto clear on vectoring is exercised too.
        wr(ADDR_TMR_CTRL, 8'h01);
        wr(ADDR_IRQ_EN, 8'h81);
        @(posedge clk_sys);
        p0n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        p0n <= 1'b1;
        take(SRC_EXT0, 1'b0, "edge call 0");
        rd(ADDR_TMR_CTRL, 8'h01, "edge flag 0 auto clear");
        ret_irq();
        $display("test ext done");
    endtask : t_ext

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // A hang in any scenario ends the run here as a failure.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        sys_rst = 1'b1;
        bus     = '0;
        evt     = '0;
        p0n     = 1'b1;
        p1n     = 1'b1;
        dly     = 4'h0;
        ret_go  = 1'b0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs();
        t_gate();
        t_timing();
        t_soft();
        t_prio();
        t_ext();
        conclude();
    end
endmodule : icr_handler_tb
`default_nettype wire
